// File: verilog/pim_ctrl.v
`include "pim_defs.vh"
module pim_ctrl #(
  parameter NSRC = 15,
  parameter NCH = 8,
  parameter WDT_CYCLES = `PIM_WDT_MIN_US * `PIM_CLK_MHZ
) (
  input wire mclk,
  input wire sys_rst,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [14:0] reqFlag,
  input wire extNmiPin,
  input wire swBreak,
  output wire cpuReq,
  output wire [15:0] cpuVector,
  output wire cpuCtxSwitch,
  input wire cpuAck,
  input wire [15:0] cpuPc,
  output wire [15:0] cpuPsw,
  output wire cpuHalted,
  output wire clockStopped,
  output wire memReq,
  output wire memWe,
  output wire memWord,
  output wire [15:0] memAddr,
  output wire [15:0] memWdata,
  input wire [15:0] memRdata,
  input wire memAck,
  output wire sfrReq,
  output wire sfrWe,
  output wire sfrWord,
  output wire [7:0] sfrSel,
  output wire [15:0] sfrWdata,
  input wire [15:0] sfrRdata,
  input wire sfrAck
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_OFFER = 5'b00010;
  localparam [4:0] S_SRC = 5'b00100;
  localparam [4:0] S_DST = 5'b01000;
  localparam [4:0] S_UPD = 5'b10000;

  reg [4:0] st_q;
  reg busAck_q;
  reg [31:0] rdata_q;
  reg [2:0] ctrl_q;
  reg [15:0] psw_q;
  reg [14:0] level_q;
  reg [14:0] mask_q;
  reg [14:0] csel_q;
  reg [14:0] men_q;
  reg [14:0] pend_q;
  reg [31:0] mch_q;
  reg [23:0] mmode_q;
  reg [15:0] savePc_q;
  reg [15:0] savePsw_q;
  reg [31:0] chRec [0:NCH-1];
  reg boot_q;
  reg brkPend_q;
  reg nmiPend_q;
  reg wdtPend_q;
  reg nmiPrev_q;
  reg halt_q;
  reg stop_q;
  reg wdtEn_q;
  reg [23:0] wdtCnt_q;
  reg cpuReq_q;
  reg [15:0] vec_q;
  reg ctx_q;
  reg [2:0] offKind_q;
  reg [3:0] offSrc_q;
  reg [2:0] xCh_q;
  reg [2:0] xMode_q;
  reg [15:0] xPtr_q;
  reg [7:0] xSel_q;
  reg [15:0] xData_q;
  reg [31:0] rdMux;
  reg chHit;
  reg [2:0] chIdx;
  wire busReq = avs_read | avs_write;
  wire wrEn = avs_write & busAck_q;
  wire nmiRise = extNmiPin & ~nmiPrev_q;
  wire [14:0] live;
  wire [44:0] lvlFlat;
  wire pickValid;
  wire [3:0] pickIdx;
  wire [31:0] rec = chRec[chIdx];
  wire [2:0] pickMode = mmode_q[3*chIdx +: 3];
  wire maskOk = psw_q[`PIM_PSW_GATE] & pickValid;
  wire [14:0] macroCap = `PIM_MACRO_CAP;
  wire goMacro = men_q[pickIdx] & macroCap[pickIdx] & chHit;
  wire wdtFirst = ctrl_q[`PIM_CTRL_WDT_FIRST];
  wire [31:0] wdtLastFull = WDT_CYCLES - 1;
  wire [23:0] wdtLast = wdtLastFull[23:0];
  wire wdtRestart = wrEn && avs_address == `PIM_REG_WDOG && avs_writedata[`PIM_WDOG_RESTART];
  wire wdtFire = wdtEn_q && !stop_q && !wdtRestart && wdtCnt_q == wdtLast;
  wire [14:0] clrAck;
  wire [14:0] clrMac;
  wire [14:0] clrSw;

  function [15:0] vecOf(input [3:0] s);
    case (s)
      4'h0: vecOf = `PIM_VEC_UD0A;
      4'h1: vecOf = `PIM_VEC_UD0B;
      4'h2: vecOf = `PIM_VEC_UD1A;
      4'h3: vecOf = `PIM_VEC_UD1B;
      4'h4: vecOf = `PIM_VEC_EXT0;
      4'h5: vecOf = `PIM_VEC_EXT1;
      4'h6: vecOf = `PIM_VEC_EXT2;
      4'h7: vecOf = `PIM_VEC_TMR0;
      4'h8: vecOf = `PIM_VEC_TMR1;
      4'h9: vecOf = `PIM_VEC_TMR2;
      4'hA: vecOf = `PIM_VEC_SFLT;
      4'hB: vecOf = `PIM_VEC_SRX;
      4'hC: vecOf = `PIM_VEC_STX;
      4'hD: vecOf = `PIM_VEC_CONV;
      default: vecOf = `PIM_VEC_TICK;
    endcase
  endfunction

  function [31:0] merge(input [31:0] old, input [31:0] nw, input [3:0] be);
    merge = {be[3] ? nw[31:24] : old[31:24], be[2] ? nw[23:16] : old[23:16],
      be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction
  wire [31:0] pswMerged = merge({16'h0, psw_q}, avs_writedata, avs_byteenable);

  // Groups: counters 0-3, external 4-6, timers 7-9, serial 10-12, converter and timebase 13-14
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1) begin : gLvl
      localparam integer GRP = g < 4 ? 0 : g < 7 ? 1 : g < 10 ? 2 : g < 13 ? 3 : 4;
      assign lvlFlat[3*g +: 3] = level_q[3*GRP +: 3];
    end
  endgenerate

  assign live = pend_q & ~mask_q;
  pim_pick #(.N(NSRC), .LW(3)) u_pick (
    .req(live),
    .lvl(lvlFlat),
    .valid(pickValid),
    .idx(pickIdx)
  );

  integer c;
  // Find the channel assigned to the winning source
  always @* begin
    chHit = 1'b0;
    chIdx = 3'h0;
    for (c = NCH - 1; c >= 0; c = c - 1) begin
      if (mch_q[4*c +: 4] == pickIdx) begin
        chHit = 1'b1;
        chIdx = c[2:0];
      end
    end
  end

  always @* begin
    rdMux = 32'h00000000;
    if (avs_address[7:5] == `PIM_REG_CHREC) begin
      rdMux = chRec[avs_address[4:2]];
    end else begin
      case (avs_address)
        `PIM_REG_CTRL: rdMux = {29'h0, ctrl_q};
        `PIM_REG_PSW: rdMux = {16'h0, psw_q};
        `PIM_REG_LEVEL: rdMux = {17'h0, level_q};
        `PIM_REG_MASK: rdMux = {17'h0, mask_q};
        `PIM_REG_CSEL: rdMux = {17'h0, csel_q};
        `PIM_REG_MEN: rdMux = {17'h0, men_q};
        `PIM_REG_PEND: rdMux = {17'h0, pend_q};
        `PIM_REG_STAT: rdMux = {12'h0, offSrc_q, offKind_q, st_q, 2'h0, stop_q, halt_q,
          wdtPend_q, nmiPend_q, brkPend_q, boot_q};
        `PIM_REG_WDOG: rdMux = {31'h0, wdtEn_q};
        `PIM_REG_MCH: rdMux = mch_q;
        `PIM_REG_MMODE: rdMux = {8'h0, mmode_q};
        `PIM_REG_SAVE: rdMux = {savePsw_q, savePc_q};
        default: rdMux = 32'h00000000;
      endcase
    end
  end

  assign clrAck = (st_q == S_OFFER && cpuAck && offKind_q == `PIM_K_MASK) ? 15'h0001 << offSrc_q : 15'h0000;
  assign clrMac = (st_q == S_IDLE && !stop_q && !boot_q && !brkPend_q && !nmiPend_q && !wdtPend_q
    && maskOk && goMacro && rec[31:24] != 8'h00) ? 15'h0001 << pickIdx : 15'h0000;
  assign clrSw = (wrEn && avs_address == `PIM_REG_PEND) ? avs_writedata[14:0] : 15'h0000;

  integer k;
  always @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      busAck_q <= 1'b0;
      rdata_q <= 32'h00000000;
      ctrl_q <= 3'h0;
      psw_q <= `PIM_RST_PSW;
      level_q <= `PIM_RST_LEVEL;
      mask_q <= `PIM_RST_MASK;
      csel_q <= 15'h0000;
      men_q <= 15'h0000;
      pend_q <= 15'h0000;
      mch_q <= `PIM_RST_MCH;
      mmode_q <= 24'h000000;
      savePc_q <= 16'h0000;
      savePsw_q <= 16'h0000;
      for (k = 0; k < NCH; k = k + 1) begin
        chRec[k] <= 32'h00000000;
      end
      boot_q <= 1'b1;
      brkPend_q <= 1'b0;
      nmiPend_q <= 1'b0;
      wdtPend_q <= 1'b0;
      nmiPrev_q <= 1'b0;
      halt_q <= 1'b0;
      stop_q <= 1'b0;
      wdtEn_q <= 1'b0;
      wdtCnt_q <= 24'h000000;
      cpuReq_q <= 1'b0;
      vec_q <= 16'h0000;
      ctx_q <= 1'b0;
      offKind_q <= `PIM_K_BOOT;
      offSrc_q <= 4'h0;
      xCh_q <= 3'h0;
      xMode_q <= 3'h0;
      xPtr_q <= 16'h0000;
      xSel_q <= 8'h00;
      xData_q <= 16'h0000;
    end else begin
      busAck_q <= busReq & ~busAck_q;
      if (busReq && !busAck_q) begin
        rdata_q <= rdMux;
      end
      pend_q <= (pend_q & ~(clrAck | clrMac | clrSw)) | reqFlag;
      nmiPrev_q <= extNmiPin;
      if (halt_q && |live) begin
        halt_q <= 1'b0;
      end
      if (wrEn) begin
        if (avs_address[7:5] == `PIM_REG_CHREC) begin
          chRec[avs_address[4:2]] <= merge(chRec[avs_address[4:2]], avs_writedata, avs_byteenable);
        end
        case (avs_address)
          `PIM_REG_CTRL: begin
            ctrl_q <= {1'b0, avs_writedata[`PIM_CTRL_HALT], avs_writedata[`PIM_CTRL_WDT_FIRST]};
            if (avs_writedata[`PIM_CTRL_HALT]) begin
              halt_q <= 1'b1;
            end
            if (avs_writedata[`PIM_CTRL_STOP]) begin
              stop_q <= 1'b1;
            end
          end
          `PIM_REG_PSW: psw_q <= pswMerged[15:0];
          `PIM_REG_LEVEL: level_q <= avs_writedata[14:0];
          `PIM_REG_MASK: mask_q <= avs_writedata[14:0];
          `PIM_REG_CSEL: csel_q <= avs_writedata[14:0];
          `PIM_REG_MEN: men_q <= avs_writedata[14:0];
          `PIM_REG_MCH: mch_q <= avs_writedata;
          `PIM_REG_MMODE: mmode_q <= avs_writedata[23:0];
          `PIM_REG_WDOG: wdtEn_q <= avs_writedata[`PIM_WDOG_EN];
          default: ;
        endcase
      end
      // Watchdog counts while enabled and not stopped; a restart write clears it
      if (wdtRestart) begin
        wdtCnt_q <= 24'h000000;
      end else if (wdtEn_q && !stop_q) begin
        if (wdtFire) begin
          wdtCnt_q <= 24'h000000;
        end else begin
          wdtCnt_q <= wdtCnt_q + 24'h000001;
        end
      end
      case (st_q)
        S_IDLE: begin
          if (stop_q) begin
            st_q <= S_IDLE;
          end else if (boot_q) begin
            vec_q <= `PIM_VEC_RESET;
            ctx_q <= 1'b0;
            offKind_q <= `PIM_K_BOOT;
            cpuReq_q <= 1'b1;
            st_q <= S_OFFER;
          end else if (brkPend_q) begin
            vec_q <= `PIM_VEC_BREAK;
            ctx_q <= 1'b0;
            offKind_q <= `PIM_K_BREAK;
            cpuReq_q <= 1'b1;
            st_q <= S_OFFER;
          end else if (wdtPend_q && (wdtFirst || !nmiPend_q)) begin
            vec_q <= `PIM_VEC_WDT;
            ctx_q <= 1'b0;
            offKind_q <= `PIM_K_WDT;
            cpuReq_q <= 1'b1;
            st_q <= S_OFFER;
          end else if (nmiPend_q) begin
            vec_q <= `PIM_VEC_NMI;
            ctx_q <= 1'b0;
            offKind_q <= `PIM_K_NMI;
            cpuReq_q <= 1'b1;
            st_q <= S_OFFER;
          end else if (maskOk) begin
            if (goMacro && rec[31:24] != 8'h00) begin
              xCh_q <= chIdx;
              xMode_q <= pickMode;
              xPtr_q <= rec[15:0];
              xSel_q <= rec[23:16];
              st_q <= S_SRC;
            end else begin
              if (goMacro) begin
                men_q[pickIdx] <= 1'b0;
              end
              vec_q <= vecOf(pickIdx);
              ctx_q <= csel_q[pickIdx];
              offKind_q <= `PIM_K_MASK;
              offSrc_q <= pickIdx;
              cpuReq_q <= 1'b1;
              st_q <= S_OFFER;
            end
          end
        end
        S_OFFER: begin
          if (cpuAck) begin
            cpuReq_q <= 1'b0;
            psw_q[`PIM_PSW_GATE] <= 1'b0;
            if (ctx_q) begin
              savePc_q <= cpuPc;
              savePsw_q <= psw_q;
              psw_q[`PIM_PSW_BANK +: 3] <= lvlFlat[3*offSrc_q +: 3];
            end
            case (offKind_q)
              `PIM_K_BOOT: boot_q <= 1'b0;
              `PIM_K_BREAK: brkPend_q <= 1'b0;
              `PIM_K_NMI: nmiPend_q <= 1'b0;
              `PIM_K_WDT: wdtPend_q <= 1'b0;
              default: ;
            endcase
            st_q <= S_IDLE;
          end
        end
        S_SRC: begin
          if (xMode_q[`PIM_MODE_TO_SFR] ? memAck : sfrAck) begin
            xData_q <= xMode_q[`PIM_MODE_TO_SFR] ? memRdata : sfrRdata;
            st_q <= S_DST;
          end
        end
        S_DST: begin
          if (xMode_q[`PIM_MODE_TO_SFR] ? sfrAck : memAck) begin
            st_q <= S_UPD;
          end
        end
        S_UPD: begin
          if (xMode_q[`PIM_MODE_INC]) begin
            chRec[xCh_q][15:0] <= xPtr_q + (xMode_q[`PIM_MODE_WORD] ? 16'h0002 : 16'h0001);
          end
          chRec[xCh_q][31:24] <= chRec[xCh_q][31:24] - 8'h01;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
      // Set after the offer logic so a timeout in the acceptance cycle is kept
      if (wdtFire) begin
        wdtPend_q <= 1'b1;
      end
      if (swBreak) begin
        brkPend_q <= 1'b1;
      end
      if (nmiRise) begin
        nmiPend_q <= 1'b1;
        stop_q <= 1'b0;
      end
    end
  end

  assign avs_waitrequest = busReq & ~busAck_q;
  assign avs_readdata = rdata_q;
  assign cpuReq = cpuReq_q;
  assign cpuVector = vec_q;
  assign cpuCtxSwitch = ctx_q;
  assign cpuPsw = psw_q;
  assign cpuHalted = halt_q | stop_q;
  assign clockStopped = stop_q;
  assign memReq = (st_q == S_SRC && xMode_q[`PIM_MODE_TO_SFR]) || (st_q == S_DST && !xMode_q[`PIM_MODE_TO_SFR]);
  assign memWe = st_q == S_DST;
  assign memWord = xMode_q[`PIM_MODE_WORD];
  assign memAddr = xPtr_q;
  assign memWdata = xData_q;
  assign sfrReq = (st_q == S_SRC && !xMode_q[`PIM_MODE_TO_SFR]) || (st_q == S_DST && xMode_q[`PIM_MODE_TO_SFR]);
  assign sfrWe = st_q == S_DST;
  assign sfrWord = xMode_q[`PIM_MODE_WORD];
  assign sfrSel = xSel_q;
  assign sfrWdata = xData_q;
endmodule // pim_ctrl

// File: verilog/pim_defs.vh
`ifndef PIM_DEFS_VH
`define PIM_DEFS_VH
// Register byte offsets on the Avalon-MM slave
`define PIM_REG_CTRL 8'h00
`define PIM_REG_PSW 8'h04
`define PIM_REG_LEVEL 8'h08
`define PIM_REG_MASK 8'h0C
`define PIM_REG_CSEL 8'h10
`define PIM_REG_MEN 8'h14
`define PIM_REG_PEND 8'h18
`define PIM_REG_STAT 8'h1C
`define PIM_REG_WDOG 8'h20
`define PIM_REG_MCH 8'h24
`define PIM_REG_MMODE 8'h28
`define PIM_REG_SAVE 8'h2C
`define PIM_REG_CHREC 3'h2
// Field positions
`define PIM_CTRL_WDT_FIRST 0
`define PIM_CTRL_HALT 1
`define PIM_CTRL_STOP 2
`define PIM_WDOG_EN 0
`define PIM_WDOG_RESTART 1
`define PIM_PSW_GATE 9
`define PIM_PSW_BANK 12
`define PIM_MODE_TO_SFR 0
`define PIM_MODE_WORD 1
`define PIM_MODE_INC 2
// Reset values
`define PIM_RST_LEVEL 15'h7FFF
`define PIM_RST_MASK 15'h7FFF
`define PIM_RST_MCH 32'hFFFFFFFF
`define PIM_RST_PSW 16'h0000
// Sources allowed to use autonomous transfer
`define PIM_MACRO_CAP 15'h3BF5
// Fixed vectors
`define PIM_VEC_RESET 16'h0000
`define PIM_VEC_BREAK 16'h003E
`define PIM_VEC_NMI 16'h0002
`define PIM_VEC_WDT 16'h000A
`define PIM_VEC_UD0A 16'h001A
`define PIM_VEC_UD0B 16'h001C
`define PIM_VEC_UD1A 16'h001E
`define PIM_VEC_UD1B 16'h0020
`define PIM_VEC_EXT0 16'h0004
`define PIM_VEC_EXT1 16'h0006
`define PIM_VEC_EXT2 16'h0008
`define PIM_VEC_TMR0 16'h000E
`define PIM_VEC_TMR1 16'h0010
`define PIM_VEC_TMR2 16'h0012
`define PIM_VEC_SFLT 16'h0022
`define PIM_VEC_SRX 16'h0024
`define PIM_VEC_STX 16'h0026
`define PIM_VEC_CONV 16'h0028
`define PIM_VEC_TICK 16'h000C
// Kinds of offered entry
`define PIM_K_BOOT 3'h0
`define PIM_K_BREAK 3'h1
`define PIM_K_NMI 3'h2
`define PIM_K_WDT 3'h3
`define PIM_K_MASK 3'h4
// Timing
`define PIM_CLK_MHZ 20
`define PIM_WDT_MIN_US 5500
`endif

// File: verilog/pim_pick.v
module pim_pick #(
  parameter N = 15,
  parameter LW = 3
) (
  input wire [N-1:0] req,
  input wire [N*LW-1:0] lvl,
  output reg valid,
  output reg [3:0] idx
);
  reg [LW-1:0] best;
  integer i;
  // Lowest level wins; equal levels go to the lower source number
  always @* begin
    valid = 1'b0;
    idx = 4'h0;
    best = {LW{1'b1}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i] && (!valid || lvl[i*LW +: LW] <= best)) begin
        valid = 1'b1;
        idx = i[3:0];
        best = lvl[i*LW +: LW];
      end
    end
  end
endmodule // pim_pick

// File: tb/pim_cpu_model.sv
module pim_cpu_model (
  input wire mclk,
  input wire [1:0] dly,
  input wire cpuReq,
  input wire [15:0] cpuVector,
  input wire cpuCtxSwitch,
  output logic cpuAck,
  output logic [15:0] cpuPc,
  input wire memReq,
  input wire memWe,
  input wire [15:0] memAddr,
  input wire [15:0] memWdata,
  output logic [15:0] memRdata,
  output logic memAck,
  input wire sfrReq,
  input wire sfrWe,
  input wire [7:0] sfrSel,
  input wire [15:0] sfrWdata,
  output logic [15:0] sfrRdata,
  output logic sfrAck,
  output logic [15:0] lastVec,
  output logic [15:0] lastAddr,
  output logic [15:0] lastData,
  output logic [7:0] lastSel,
  output logic lastCtx,
  output int nOffers,
  output int nMoves
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt = '0;
  assign cpuPc = 16'h2468;
  initial begin
    {cpuAck, memAck, sfrAck, lastVec, lastAddr, lastData, lastSel, lastCtx} = '0;
    {memRdata, sfrRdata, nOffers, nMoves} = '0;
  end
  // Answers after dly extra cycles; idle read lines toggle
  always @(posedge mclk) begin
    cpuAck <= 1'h0;
    memAck <= 1'h0;
    sfrAck <= 1'h0;
    memRdata <= memReq ? 16'h96E1 : ~memRdata;
    sfrRdata <= sfrReq ? 16'hC35A : ~sfrRdata;
    if ((cpuReq || memReq || sfrReq) && !(cpuAck || memAck || sfrAck)) begin
      cnt <= cnt + 2'h1;
      if (cnt >= dly) begin
        cnt <= '0;
        cpuAck <= cpuReq;
        memAck <= memReq;
        sfrAck <= sfrReq;
      end
    end
    if (cpuAck && cpuReq) begin
      lastVec <= cpuVector;
      lastCtx <= cpuCtxSwitch;
      nOffers <= nOffers + 1;
    end
    if (sfrAck && sfrReq && sfrWe) begin
      lastSel <= sfrSel;
      lastData <= sfrWdata;
      nMoves <= nMoves + 1;
    end
    if (memAck && memReq && memWe) begin
      lastAddr <= memAddr;
      lastData <= memWdata;
      nMoves <= nMoves + 1;
    end
  end
endmodule // pim_cpu_model

// File: tb/pim_ctrl_asserts.sv
module pim_ctrl_asserts (
  input wire mclk,
  input wire sys_rst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire cpuReq,
  input wire cpuAck,
  input wire [15:0] cpuVector,
  input wire [15:0] cpuPsw,
  input wire clockStopped,
  input wire memReq,
  input wire memAck,
  input wire sfrReq,
  input wire sfrAck
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_open;
    (avs_read || avs_write) && !$past(avs_read || avs_write);
  endsequence
  sequence s_take;
    cpuReq && cpuAck;
  endsequence
  a_one_wait: assert property (s_open |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus wait state wrong");
  a_boot_offer: assert property ($fell(sys_rst) |-> ##[0:1] (cpuReq && cpuVector == 16'h0000))
    else $error("no boot offer");
  a_offer_hold: assert property (cpuReq && !cpuAck |=> cpuReq && $stable(cpuVector))
    else $error("offer not held");
  a_offer_drop: assert property (s_take |=> !cpuReq)
    else $error("offer stays after ack");
  a_gate_shut: assert property (s_take |=> !cpuPsw[9])
    else $error("gate open after entry");
  a_stop_quiet: assert property (clockStopped |-> !$rose(cpuReq))
    else $error("offer while stopped");
  a_mem_hold: assert property (memReq && !memAck |=> memReq)
    else $error("memory request dropped");
  a_sfr_hold: assert property (sfrReq && !sfrAck |=> sfrReq)
    else $error("register request dropped");
  a_one_side: assert property (!(memReq && sfrReq))
    else $error("both sides requested");
endmodule // pim_ctrl_asserts
bind pim_ctrl pim_ctrl_asserts chkr (.*);

// File: tb/pim_ctrl_tb.sv
`include "pim_defs.vh"
module pim_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic extNmiPin = 1'h0;
  logic swBreak = 1'h0;
  logic [7:0] avs_address = '0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [14:0] reqFlag = '0;
  logic [1:0] dly = '0;
  logic [31:0] avs_readdata, rv;
  logic avs_waitrequest, cpuReq, cpuCtxSwitch, cpuAck, cpuHalted, clockStopped;
  logic memReq, memWe, memWord, memAck, sfrReq, sfrWe, sfrWord, sfrAck;
  logic [15:0] cpuVector, cpuPc, cpuPsw, memAddr, memWdata, memRdata, sfrWdata, sfrRdata;
  logic [15:0] lastVec, lastAddr, lastData;
  logic [7:0] sfrSel, lastSel;
  logic lastCtx;
  int nOffers, nMoves, k, k2, cyc = 0, n_errors = 0, num_checks = 0;
  logic [15:0] vecs [15] = '{16'h001A, 16'h001C, 16'h001E, 16'h0020, 16'h0004, 16'h0006, 16'h0008,
    16'h000E, 16'h0010, 16'h0012, 16'h0022, 16'h0024, 16'h0026, 16'h0028, 16'h000C};
  logic [15:0] pv [3] = '{16'h0004, 16'h0006, 16'h001A};
  pim_ctrl #(.WDT_CYCLES(50)) dut (.*);
  pim_cpu_model cpu (.*);
  initial begin
    forever #25 mclk = ~mclk;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge mclk); while (avs_waitrequest !== 1'h0);
    rv = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task pulse(input logic [14:0] m);
    k = nOffers;
    @(posedge mclk);
    reqFlag <= m;
    @(posedge mclk);
    reqFlag <= '0;
  endtask
  // Waits for the next accepted entry and compares its vector
  task offer(input logic [15:0] v);
    repeat (200) if (nOffers == k) @(negedge mclk);
    chk({lastVec, 16'(nOffers - k)}, {v, 16'h1});
    k = nOffers;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'h0;
    k = 0;
    offer(16'h0000);
    bus(1'h0, `PIM_REG_LEVEL, '0);
    chk(rv, 32'h7FFF);
    bus(1'h0, `PIM_REG_MASK, '0);
    chk(rv, 32'h7FFF);
    bus(1'h0, 8'h3C, '0);
    chk(rv, '0);
    $display("reset done");
    bus(1'h1, `PIM_REG_MASK, '0);
    for (int i = 0; i < 15; i++) begin
      bus(1'h1, `PIM_REG_PSW, 32'h200);
      pulse(15'(1 << i));
      offer(vecs[i]);
      bus(1'h0, `PIM_REG_PEND, '0);
      chk(rv, '0);
    end
    $display("vector table done");
    bus(1'h1, `PIM_REG_LEVEL, 32'h7FC7);
    pulse(15'h0031);
    for (int i = 0; i < 3; i++) begin
      bus(1'h1, `PIM_REG_PSW, 32'h200);
      offer(pv[i]);
    end
    $display("priority done");
    @(posedge mclk);
    extNmiPin <= 1'h1;
    swBreak <= 1'h1;
    @(posedge mclk);
    swBreak <= 1'h0;
    offer(16'h003E);
    offer(16'h0002);
    bus(1'h1, `PIM_REG_WDOG, 32'h1);
    repeat (4) begin
      repeat (20) @(posedge mclk);
      bus(1'h1, `PIM_REG_WDOG, 32'h3);
    end
    chk(nOffers - k, 0);
    offer(16'h000A);
    bus(1'h1, `PIM_REG_WDOG, '0);
    $display("nonmaskable done");
    dly <= 2'h2;
    bus(1'h1, `PIM_REG_MCH, 32'hFFFFFFF4);
    bus(1'h1, `PIM_REG_MMODE, 32'h6);
    bus(1'h1, 8'h40, 32'h025A1000);
    bus(1'h1, `PIM_REG_MEN, 32'hFFFF);
    bus(1'h1, `PIM_REG_PSW, 32'h200);
    for (int i = 0; i < 2; i++) begin
      k2 = nMoves;
      pulse(15'h10);
      repeat (200) if (nMoves == k2) @(negedge mclk);
      chk({lastAddr, lastData}, {16'h1000 + 16'(2 * i), 16'hC35A});
    end
    chk(nOffers - k, 0);
    bus(1'h0, 8'h40, '0);
    chk(rv, 32'h005A1004);
    bus(1'h1, `PIM_REG_MMODE, 32'h1);
    bus(1'h1, 8'h40, 32'h01A53000);
    k2 = nMoves;
    pulse(15'h10);
    repeat (200) if (nMoves == k2) @(negedge mclk);
    chk({lastSel, lastData}, {8'hA5, 16'h96E1});
    bus(1'h0, 8'h40, '0);
    chk(rv, 32'h00A53000);
    pulse(15'h10);
    offer(16'h0004);
    $display("transfer done");
    bus(1'h1, `PIM_REG_LEVEL, 32'h7F47);
    bus(1'h1, `PIM_REG_CSEL, 32'h100);
    bus(1'h1, `PIM_REG_PSW, 32'h200);
    bus(1'h1, `PIM_REG_CTRL, 32'h2);
    @(negedge mclk);
    chk(cpuHalted, 1);
    pulse(15'h80);
    offer(16'h000E);
    chk(cpuHalted, 0);
    bus(1'h1, `PIM_REG_PSW, 32'h200);
    bus(1'h1, `PIM_REG_CTRL, 32'h4);
    pulse(15'h100);
    repeat (10) @(posedge mclk);
    extNmiPin <= 1'h0;
    chk({clockStopped, 16'(nOffers - k)}, {1'h1, 16'h0});
    @(posedge mclk);
    extNmiPin <= 1'h1;
    offer(16'h0002);
    chk(clockStopped, 0);
    bus(1'h1, `PIM_REG_PSW, 32'h200);
    offer(16'h0010);
    chk({lastCtx, cpuPsw}, {1'h1, 16'h5000});
    bus(1'h0, `PIM_REG_SAVE, '0);
    chk(rv, 32'h02002468);
    $display("standby done");
    wrap_up();
  end
endmodule // pim_ctrl_tb
